// ===== sic_pkg.sv
// Register map, field positions and constants for the SPI status/CRC block
package sic_pkg;
  localparam logic [15:0] SIC_OFS_PORT_CTRL = 16'hc0ca;
  localparam logic [15:0] SIC_OFS_IRQ_EN    = 16'hc0cc;
  localparam logic [15:0] SIC_OFS_STATUS    = 16'hc0ce;
  localparam logic [15:0] SIC_OFS_IRQ_CLR   = 16'hc0d0;
  localparam logic [15:0] SIC_OFS_CRC_CTRL  = 16'hc0d2;
  localparam logic [15:0] SIC_OFS_DATA      = 16'hc0d6;
  // Port control fields
  localparam int SIC_PC_FIFO_INIT  = 14;
  localparam int SIC_PC_BYTE_MODE  = 13;
  localparam int SIC_PC_FULL_DUP   = 12;
  localparam int SIC_PC_SS_MANUAL  = 11;
  localparam int SIC_PC_READ_EN    = 10;
  localparam int SIC_PC_TX_READY   = 9;
  localparam int SIC_PC_RX_READY   = 8;
  localparam int SIC_PC_TX_EMPTY   = 7;
  localparam int SIC_PC_RX_FULL    = 6;
  localparam int SIC_PC_TXLEN_HI   = 5;
  localparam int SIC_PC_TXLEN_LO   = 3;
  localparam int SIC_PC_RXLEN_HI   = 2;
  localparam int SIC_PC_RXLEN_LO   = 0;
  // Interrupt enable / status / clear fields
  localparam int SIC_IRQ_RX        = 2;
  localparam int SIC_IRQ_TX        = 1;
  localparam int SIC_IRQ_BLK       = 0;
  localparam int SIC_ST_FIFO_ERR   = 7;
  // CRC control fields
  localparam int SIC_CRC_MODE_HI   = 15;
  localparam int SIC_CRC_MODE_LO   = 14;
  localparam int SIC_CRC_ENABLE    = 13;
  localparam int SIC_CRC_CLEAR     = 12;
  localparam int SIC_CRC_RX_SRC    = 11;
  localparam int SIC_CRC_ONE_IN    = 10;
  localparam int SIC_CRC_ZERO_IN   = 9;
  // Polynomial select codes and taps
  localparam logic [1:0]  SIC_POLY_CCITT = 2'h0;
  localparam logic [1:0]  SIC_POLY_CRC7  = 2'h1;
  localparam logic [1:0]  SIC_POLY_ALT16 = 2'h2;
  localparam logic [15:0] SIC_TAPS_CCITT = 16'h1021;
  localparam logic [15:0] SIC_TAPS_CRC7  = 16'h0009;
  localparam logic [15:0] SIC_TAPS_ALT16 = 16'h8005;
  localparam logic [15:0] SIC_TAPS_RSVD  = 16'h0001;
  localparam logic [15:0] SIC_CRC7_MASK  = 16'h007f;
  localparam logic [15:0] SIC_CRC_PRESET = 16'hffff;
  // Reset values and sizes
  localparam logic [15:0] SIC_RST_ZERO   = 16'h0000;
  localparam logic [2:0]  SIC_LEN_FULL   = 3'h0;
  localparam logic [3:0]  SIC_BITS_BYTE  = 4'h8;
  localparam int          SIC_RXF_DEPTH  = 8;
  localparam logic [3:0]  SIC_RXF_FULLC  = 4'h8;
endpackage

// ===== sic_top.sv
// SPI interrupt, status and CRC control block with slave shift engine
//
// Summary of operation
// R01: Tx length 000 sends byte, else N bits
// R02: Rx length 000 captures byte, else N bits
// R03: Control bit 6 reads receive FIFO full
// R04: Enable bit 2 gates byte receive interrupt
// R05: Enable bit 1 gates byte transmit interrupt
// R06: Enable bit 0 gates block interrupt
// R07: Status word read-only, writes ignored
// R08: FIFO error flag; with tx empty, underflow
// R09: FIFO error with receive full means overflow
// R10: FIFO init command clears FIFO error flag
// R11: Status bit 2 shows receive interrupt triggered
// R12: Status bit 1 shows transmit interrupt triggered
// R13: Status bit 0 shows block interrupt triggered
// R14: Clear bit 1 clears transmit interrupt
// R15: Clear bit 0 clears block interrupt
// R16: Software writes zero to reserved bits
// R17: Two-bit select picks CRC polynomial
// R18: CRC enable bit turns accumulation on
// R19: CRC clear presets all ones, reads zero
// R20: Full duplex: bit 11 picks CRC stream
// R21: Bits 10/9 flag CRC not zero/ones
// R22: CRC7 mode uses only low seven bits
// R23: Byte-mode data write starts a transfer
// R24: Interrupt request when flag and enable set
// R25: Enable and CRC control reset to zero
//
// Chosen here: the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
module sic_top
  import sic_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        reset,
  input  wire logic [15:0] reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  input  wire logic        three_wire_en,
  input  wire logic        block_done,
  input  wire logic        spi_sck,
  input  wire logic        spi_ss_n,
  input  wire logic        spi_mosi,
  output logic             spi_miso_o,
  output logic             spi_miso_oe,
  output logic             spi_irq
);

  // ----------------------------------------
  // Register decode
  // ----------------------------------------
  logic wr_pc;
  logic wr_en;
  logic wr_clr;
  logic wr_crc;
  logic wr_data;
  logic rd_data;
  assign wr_pc   = reg_wr && (reg_addr == SIC_OFS_PORT_CTRL);
  assign wr_en   = reg_wr && (reg_addr == SIC_OFS_IRQ_EN);
  assign wr_clr  = reg_wr && (reg_addr == SIC_OFS_IRQ_CLR);
  assign wr_crc  = reg_wr && (reg_addr == SIC_OFS_CRC_CTRL);
  assign wr_data = reg_wr && (reg_addr == SIC_OFS_DATA);
  assign rd_data = reg_rd && (reg_addr == SIC_OFS_DATA);

  logic fifo_init;
  assign fifo_init = wr_pc && reg_wdata[SIC_PC_FIFO_INIT];

  // ----------------------------------------
  // Control registers
  // ----------------------------------------
  logic       byte_mode_q;
  logic       full_dup_q;
  logic       ss_manual_q;
  logic       read_en_q;
  logic [2:0] tx_len_q;
  logic [2:0] rx_len_q;

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      byte_mode_q <= 1'b0;
      full_dup_q  <= 1'b0;
      ss_manual_q <= 1'b0;
      read_en_q   <= 1'b0;
      tx_len_q    <= SIC_LEN_FULL;
      rx_len_q    <= SIC_LEN_FULL;
    end
    else if (wr_pc)
    begin
      byte_mode_q <= reg_wdata[SIC_PC_BYTE_MODE];
      // Full duplex cannot be set with the data lines tied
      full_dup_q  <= reg_wdata[SIC_PC_FULL_DUP] && !three_wire_en;
      ss_manual_q <= reg_wdata[SIC_PC_SS_MANUAL];
      read_en_q   <= reg_wdata[SIC_PC_READ_EN];
      tx_len_q    <= reg_wdata[SIC_PC_TXLEN_HI:SIC_PC_TXLEN_LO];
      rx_len_q    <= reg_wdata[SIC_PC_RXLEN_HI:SIC_PC_RXLEN_LO];
    end
  end

  logic [2:0] irq_en_q;

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      irq_en_q <= SIC_RST_ZERO[2:0]; // R25
    else if (wr_en)
      irq_en_q <= reg_wdata[2:0];
  end

  logic [1:0] crc_mode_q;
  logic       crc_on_q;
  logic       crc_rx_src_q;

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      crc_mode_q   <= SIC_RST_ZERO[1:0]; // R25
      crc_on_q     <= 1'b0;
      crc_rx_src_q <= 1'b0;
    end
    else if (wr_crc)
    begin
      crc_mode_q   <= reg_wdata[SIC_CRC_MODE_HI:SIC_CRC_MODE_LO];
      crc_on_q     <= reg_wdata[SIC_CRC_ENABLE]; // R18
      crc_rx_src_q <= reg_wdata[SIC_CRC_RX_SRC];
    end
  end

  // ----------------------------------------
  // Link input synchronisers
  // ----------------------------------------
  logic [1:0] sck_sync_q;
  logic [1:0] ss_sync_q;
  logic [1:0] mosi_sync_q;
  logic       sck_last_q;

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      sck_sync_q  <= 2'h0;
      ss_sync_q   <= 2'h3;
      mosi_sync_q <= 2'h0;
      sck_last_q  <= 1'b0;
    end
    else
    begin
      sck_sync_q  <= {sck_sync_q[0], spi_sck};
      ss_sync_q   <= {ss_sync_q[0], spi_ss_n};
      mosi_sync_q <= {mosi_sync_q[0], spi_mosi};
      sck_last_q  <= sck_sync_q[1];
    end
  end

  logic sel;
  logic sck_rise;
  logic sck_fall;
  logic mosi_s;
  assign sel      = !ss_sync_q[1];
  assign sck_rise = sel && sck_sync_q[1] && !sck_last_q;
  assign sck_fall = sel && !sck_sync_q[1] && sck_last_q;
  assign mosi_s   = mosi_sync_q[1];

  // ----------------------------------------
  // Transmit shifter
  // ----------------------------------------
  logic [7:0] tx_sr_q;
  logic [3:0] tx_cnt_q;
  logic       tx_busy_q;
  logic [3:0] tx_bits;
  logic [2:0] tx_pad;
  logic       tx_done;
  logic       tx_bit;

  // Partial lengths send the low bits of the byte, MSB first
  assign tx_bits = (tx_len_q == SIC_LEN_FULL) ? SIC_BITS_BYTE
                                              : {1'b0, tx_len_q}; // R01
  assign tx_pad  = 3'(SIC_BITS_BYTE - tx_bits);
  assign tx_bit  = tx_sr_q[7];
  assign tx_done = tx_busy_q && sck_rise
                   && (tx_cnt_q == tx_bits - 4'h1); // R01

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      tx_sr_q   <= 8'h00;
      tx_cnt_q  <= 4'h0;
      tx_busy_q <= 1'b0;
    end
    else if (fifo_init)
    begin
      tx_cnt_q  <= 4'h0;
      tx_busy_q <= 1'b0;
    end
    else if (wr_data && byte_mode_q && !tx_busy_q)
    begin
      tx_sr_q   <= reg_wdata[7:0] << tx_pad; // R23
      tx_cnt_q  <= 4'h0;
      tx_busy_q <= 1'b1; // R23
    end
    else if (tx_busy_q)
    begin
      if (tx_done)
        tx_busy_q <= 1'b0;
      if (sck_rise)
        tx_cnt_q <= tx_cnt_q + 4'h1;
      if (sck_fall)
        tx_sr_q <= {tx_sr_q[6:0], 1'b0};
    end
  end

  assign spi_miso_o  = tx_bit;
  assign spi_miso_oe = sel && !read_en_q;

  // ----------------------------------------
  // Receive shifter and 8-byte FIFO
  // ----------------------------------------
  logic [7:0] rx_sr_q;
  logic [3:0] rx_cnt_q;
  logic [3:0] rx_bits;
  logic       rx_push;
  logic [7:0] rx_byte;

  assign rx_bits = (rx_len_q == SIC_LEN_FULL) ? SIC_BITS_BYTE
                                              : {1'b0, rx_len_q}; // R02
  assign rx_push = sck_rise && (rx_cnt_q == rx_bits - 4'h1); // R02
  // A new unit starts from zero so short lengths read back clean
  assign rx_byte = {((rx_cnt_q == 4'h0) ? 7'h00 : rx_sr_q[6:0]),
                    mosi_s}; // R02

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      rx_sr_q  <= 8'h00;
      rx_cnt_q <= 4'h0;
    end
    else if (fifo_init || !sel)
      rx_cnt_q <= 4'h0;
    else if (sck_rise)
    begin
      rx_sr_q  <= rx_byte;
      rx_cnt_q <= rx_push ? 4'h0 : rx_cnt_q + 4'h1;
    end
  end

  logic [7:0] rxf_mem [SIC_RXF_DEPTH];
  logic [2:0] rxf_wp_q;
  logic [2:0] rxf_rp_q;
  logic [3:0] rxf_cnt_q;
  logic       rxf_full;
  logic       rxf_empty;
  logic       rxf_wr;
  logic       rxf_rd;

  assign rxf_full  = (rxf_cnt_q == SIC_RXF_FULLC);
  assign rxf_empty = (rxf_cnt_q == 4'h0);
  assign rxf_wr    = rx_push && !rxf_full;
  assign rxf_rd    = rd_data && !rxf_empty;

  always_ff @(posedge sys_clk)
  begin
    if (rxf_wr)
      rxf_mem[rxf_wp_q] <= rx_byte;
  end

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      rxf_wp_q  <= 3'h0;
      rxf_rp_q  <= 3'h0;
      rxf_cnt_q <= 4'h0;
    end
    else if (fifo_init)
    begin
      rxf_wp_q  <= 3'h0;
      rxf_rp_q  <= 3'h0;
      rxf_cnt_q <= 4'h0;
    end
    else
    begin
      if (rxf_wr)
        rxf_wp_q <= rxf_wp_q + 3'h1;
      if (rxf_rd)
        rxf_rp_q <= rxf_rp_q + 3'h1;
      rxf_cnt_q <= rxf_cnt_q + {3'h0, rxf_wr} - {3'h0, rxf_rd};
    end
  end

  // ----------------------------------------
  // Status flags
  // ----------------------------------------
  logic fifo_err_q;
  logic rx_flag_q;
  logic tx_flag_q;
  logic blk_flag_q;
  logic underflow;
  logic overflow;

  // Clocking with nothing loaded while writing is a transmit underflow
  assign underflow = sck_rise && byte_mode_q && !tx_busy_q
                     && !read_en_q;
  assign overflow  = rx_push && rxf_full; // R09

  // Set beats clear in the same cycle for every flag
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      fifo_err_q <= 1'b0;
    else if (underflow || overflow)
      fifo_err_q <= 1'b1; // R08
    else if (fifo_init)
      fifo_err_q <= 1'b0; // R10
  end

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      rx_flag_q <= 1'b0;
    else if (rxf_wr && byte_mode_q)
      rx_flag_q <= 1'b1; // R11
    else if (fifo_init || (rxf_rd && rxf_cnt_q == 4'h1))
      rx_flag_q <= 1'b0;
  end

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      tx_flag_q <= 1'b0;
    else if (tx_done && byte_mode_q)
      tx_flag_q <= 1'b1; // R12
    else if (wr_clr && reg_wdata[SIC_IRQ_TX])
      tx_flag_q <= 1'b0; // R14
  end

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      blk_flag_q <= 1'b0;
    else if (block_done && !byte_mode_q)
      blk_flag_q <= 1'b1; // R13
    else if (wr_clr && reg_wdata[SIC_IRQ_BLK])
      blk_flag_q <= 1'b0; // R15
  end

  logic [2:0] flags;
  assign flags = {rx_flag_q, tx_flag_q, blk_flag_q};
  // R04 R05 R06 R24
  assign spi_irq = |(flags & irq_en_q);

  // ----------------------------------------
  // CRC accumulator
  // ----------------------------------------
  logic [15:0] crc_q;
  logic [15:0] taps;
  logic [15:0] crc_next;
  logic        crc_in;
  logic        crc_fb;
  logic        crc_step;
  logic        use_rx;
  logic [15:0] crc_view;

  always_comb
  begin
    unique case (crc_mode_q) // R17
      SIC_POLY_CCITT: taps = SIC_TAPS_CCITT;
      SIC_POLY_CRC7:  taps = SIC_TAPS_CRC7;
      SIC_POLY_ALT16: taps = SIC_TAPS_ALT16;
      default:        taps = SIC_TAPS_RSVD;
    endcase
  end

  // Half duplex follows the active direction instead
  assign use_rx   = full_dup_q ? crc_rx_src_q : read_en_q; // R20
  assign crc_in   = use_rx ? mosi_s : tx_bit;
  assign crc_step = crc_on_q && sck_rise
                    && (use_rx || tx_busy_q); // R18
  assign crc_fb   = crc_in ^ ((crc_mode_q == SIC_POLY_CRC7)
                              ? crc_q[6] : crc_q[15]); // R22
  assign crc_next = {crc_q[14:0], 1'b0} ^ (crc_fb ? taps : 16'h0000);
  assign crc_view = (crc_mode_q == SIC_POLY_CRC7)
                    ? (crc_q & SIC_CRC7_MASK) : crc_q; // R22

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      crc_q <= SIC_CRC_PRESET;
    else if (wr_crc && reg_wdata[SIC_CRC_CLEAR])
      crc_q <= SIC_CRC_PRESET; // R19
    else if (crc_step)
      crc_q <= crc_next;
  end

  logic crc_nonzero;
  logic crc_nonones;
  assign crc_nonzero = (crc_view != 16'h0000); // R21
  assign crc_nonones = (crc_mode_q == SIC_POLY_CRC7)
                       ? (crc_view != SIC_CRC7_MASK)
                       : (crc_view != SIC_CRC_PRESET); // R21

  // ----------------------------------------
  // Read path, data one cycle after strobe
  // ----------------------------------------
  logic [15:0] rd_mux;

  always_comb
  begin
    rd_mux = 16'h0000;
    if (reg_rd)
    begin
      unique case (reg_addr)
        SIC_OFS_PORT_CTRL:
        begin
          rd_mux[SIC_PC_BYTE_MODE] = byte_mode_q;
          rd_mux[SIC_PC_FULL_DUP]  = full_dup_q;
          rd_mux[SIC_PC_SS_MANUAL] = ss_manual_q;
          rd_mux[SIC_PC_READ_EN]   = read_en_q;
          rd_mux[SIC_PC_TX_READY]  = !tx_busy_q;
          rd_mux[SIC_PC_RX_READY]  = !rxf_empty;
          rd_mux[SIC_PC_TX_EMPTY]  = !tx_busy_q;
          rd_mux[SIC_PC_RX_FULL]   = rxf_full; // R03
          rd_mux[SIC_PC_TXLEN_HI:SIC_PC_TXLEN_LO] = tx_len_q;
          rd_mux[SIC_PC_RXLEN_HI:SIC_PC_RXLEN_LO] = rx_len_q;
        end
        SIC_OFS_IRQ_EN:
          rd_mux[2:0] = irq_en_q;
        SIC_OFS_STATUS: // R07
        begin
          rd_mux[SIC_ST_FIFO_ERR] = fifo_err_q;
          rd_mux[2:0] = flags;
        end
        SIC_OFS_CRC_CTRL:
        begin
          rd_mux[SIC_CRC_MODE_HI:SIC_CRC_MODE_LO] = crc_mode_q;
          rd_mux[SIC_CRC_ENABLE]  = crc_on_q;
          rd_mux[SIC_CRC_RX_SRC]  = crc_rx_src_q;
          rd_mux[SIC_CRC_ONE_IN]  = crc_nonzero;
          rd_mux[SIC_CRC_ZERO_IN] = crc_nonones;
        end
        SIC_OFS_DATA:
          rd_mux[7:0] = rxf_empty ? 8'h00 : rxf_mem[rxf_rp_q];
        default:
          rd_mux = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      reg_rdata <= 16'h0000;
    else
      reg_rdata <= rd_mux;
  end

endmodule
`default_nettype wire

// ===== sic_top_monitor.sv
// Port checker for the SPI status and CRC control block
`timescale 1ns/10ps
`default_nettype none
module sic_top_monitor
  import sic_pkg::*;
(
  input wire logic        sys_clk,
  input wire logic        reset,
  input wire logic [15:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic        spi_ss_n,
  input wire logic        spi_irq
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  logic       rd_st;
  logic       rd_crc;
  logic       wr_crc;
  logic [2:0] crc_w_q;
  assign rd_st  = reg_rd && reg_addr == SIC_OFS_STATUS;
  assign rd_crc = reg_rd && reg_addr == SIC_OFS_CRC_CTRL;
  assign wr_crc = reg_wr && reg_addr == SIC_OFS_CRC_CTRL;
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      crc_w_q <= 3'h0;
    else if (wr_crc)
      crc_w_q <= reg_wdata[15:13];
  end
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 16'h0000)
    else $error("read data not zero outside a read");
  status_rsvd_a: assert property (rd_st |=> reg_rdata[6:3] == 4'h0)
    else $error("status reserved bits not zero");
  clr_reads_a: assert property (reg_rd && reg_addr == SIC_OFS_IRQ_CLR
    |=> reg_rdata == 16'h0000)
    else $error("clear word read back non zero");
  crc_clr_a: assert property (rd_crc |=> !reg_rdata[12])
    else $error("crc clear bit read back as one");
  crc_flags_a: assert property (rd_crc |=> reg_rdata[10] || reg_rdata[9])
    else $error("crc both all zeros and all ones");
  crc_mode_a: assert property (wr_crc ##1 rd_crc
    |=> reg_rdata[15:13] == crc_w_q)
    else $error("crc mode or enable not stored");
  irq_off_a: assert property (reg_wr && reg_addr == SIC_OFS_IRQ_EN
    && reg_wdata[2:0] == 3'h0 |=> !spi_irq)
    else $error("irq with all enables off");
  tx_clr_a: assert property (reg_wr && reg_addr == SIC_OFS_IRQ_CLR
    && reg_wdata[1] && spi_ss_n ##1 rd_st |=> !reg_rdata[1])
    else $error("tx flag survived its clear");
  err_init_a: assert property (reg_wr && reg_addr == SIC_OFS_PORT_CTRL
    && reg_wdata[14] && spi_ss_n ##1 rd_st |=> !reg_rdata[7])
    else $error("fifo init left error flag set");
endmodule
bind sic_top sic_top_monitor mon (
  .sys_clk  (sys_clk),
  .reset    (reset),
  .reg_addr (reg_addr),
  .reg_wdata(reg_wdata),
  .reg_wr   (reg_wr),
  .reg_rd   (reg_rd),
  .reg_rdata(reg_rdata),
  .spi_ss_n (spi_ss_n),
  .spi_irq  (spi_irq)
);
`default_nettype wire

// ===== sic_spi_master.sv
// Behavioural SPI master facing the block's slave port
`timescale 1ns/10ps
`default_nettype none
module sic_spi_master
(
  output var logic  spi_sck,
  output var logic  spi_ss_n,
  output var logic  spi_mosi,
  input  wire logic spi_miso
);
  initial
  begin
    spi_sck  = 1'b0;
    spi_ss_n = 1'b1;
    spi_mosi = 1'b0;
  end
  // Clock idles low outside frames; 400 ns bit period, MSB first
  task automatic xfer(input int n, input logic [7:0] tx,
                      output logic [7:0] rx);
    rx = 8'h00;
    // Stay off the system clock edge so no change races its sampling
    #12 spi_ss_n = 1'b0;
    #400;
    for (int i = n - 1; i >= 0; i--)
    begin
      spi_mosi = tx[i];
      #200 spi_sck = 1'b1;
      rx = {rx[6:0], spi_miso};
      #200 spi_sck = 1'b0;
    end
    #400 spi_ss_n = 1'b1;
    // Released data line must not keep showing the last bit
    spi_mosi = ~spi_mosi;
  endtask
endmodule
`default_nettype wire

// ===== sic_top_bench.sv
// Self-checking bench for the SPI status and CRC control block
`timescale 1ns/10ps
`default_nettype none
module sic_top_bench import sic_pkg::*;;
  typedef struct packed {
    logic        w;
    logic [15:0] a;
    logic [15:0] d;
    logic [15:0] m;
    logic [15:0] e;
  } sic_row_t;
  logic        sys_clk;
  logic        reset;
  logic        reg_wr;
  logic        reg_rd;
  logic        block_done;
  logic [15:0] reg_addr;
  logic [15:0] reg_wdata;
  logic [15:0] reg_rdata;
  logic [7:0]  rxb;
  wire logic   sck;
  wire logic   ss_n;
  wire logic   mosi;
  wire logic   miso_o;
  wire logic   miso_oe;
  wire logic   miso;
  wire logic   spi_irq;
  int          fails;
  int          tests_run;
  sic_row_t    rows [12] = '{
    '{1'b0, SIC_OFS_IRQ_EN,    16'h0000, 16'hffff, 16'h0000},
    '{1'b0, SIC_OFS_CRC_CTRL,  16'h0000, 16'hf800, 16'h0000},
    '{1'b0, SIC_OFS_STATUS,    16'h0000, 16'hffff, 16'h0000},
    '{1'b1, SIC_OFS_IRQ_EN,    16'h0000, 16'hffff, 16'h0000},
    '{1'b1, SIC_OFS_IRQ_EN,    16'h0007, 16'hffff, 16'h0007},
    '{1'b1, SIC_OFS_STATUS,    16'h00ff, 16'hffff, 16'h0000},
    '{1'b1, SIC_OFS_IRQ_CLR,   16'h0003, 16'hffff, 16'h0000},
    '{1'b1, SIC_OFS_CRC_CTRL,  16'hb000, 16'hf800, 16'ha000},
    '{1'b1, SIC_OFS_CRC_CTRL,  16'h4000, 16'hf800, 16'h4000},
    '{1'b1, SIC_OFS_CRC_CTRL,  16'hc000, 16'hf800, 16'hc000},
    '{1'b1, SIC_OFS_CRC_CTRL,  16'h1000, 16'hfe00, 16'h0400},
    '{1'b0, 16'hc0c8,          16'h0000, 16'hffff, 16'h0000}};
  // Line pulled up while the slave leaves it undriven
  assign miso = miso_oe ? miso_o : 1'b1;
  sic_top dut (
    .sys_clk      (sys_clk),
    .reset        (reset),
    .reg_addr     (reg_addr),
    .reg_wdata    (reg_wdata),
    .reg_wr       (reg_wr),
    .reg_rd       (reg_rd),
    .reg_rdata    (reg_rdata),
    .three_wire_en(1'b0),
    .block_done   (block_done),
    .spi_sck      (sck),
    .spi_ss_n     (ss_n),
    .spi_mosi     (mosi),
    .spi_miso_o   (miso_o),
    .spi_miso_oe  (miso_oe),
    .spi_irq      (spi_irq)
  );
  sic_spi_master m (
    .spi_sck (sck),
    .spi_ss_n(ss_n),
    .spi_mosi(mosi),
    .spi_miso(miso)
  );
  initial sys_clk = 1'b0;
  always #25 sys_clk = ~sys_clk;
  // ----------------------------------------
  // Bus, link and compare helpers
  // ----------------------------------------
  task stop_test;
    $display("tests_run=%0d fails=%0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
    begin
      $display("*** PASS ***");
    end
    else
    begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task cmp(input logic [15:0] g, input logic [15:0] e);
    tests_run++;
    if (g !== e)
    begin
      fails++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task wr(input logic [15:0] a, input logic [15:0] d);
    // Let an edge pass between back-to-back writes
    if (reg_wr)
      @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task chk(input logic [15:0] a, input logic [15:0] mk,
           input logic [15:0] e);
    logic [15:0] r;
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(negedge sys_clk);
    r = reg_rdata;
    @(posedge sys_clk);
    cmp(r & mk, e);
  endtask
  task irq_is(input logic e);
    @(negedge sys_clk);
    cmp({15'h0000, spi_irq}, {15'h0000, e});
    @(posedge sys_clk);
  endtask
  task link(input int n, input logic [7:0] tx);
    m.xfer(n, tx, rxb);
    @(posedge sys_clk);
  endtask
  initial
  begin
    #500000;
    fails++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    stop_test;
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    reset = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    block_done = 1'b0;
    reg_addr = 16'h0000;
    reg_wdata = 16'h0000;
    repeat (16) @(posedge sys_clk);
    reset <= 1'b0;
    @(posedge sys_clk);
    foreach (rows[i])
    begin
      if (rows[i].w)
      begin
        wr(rows[i].a, rows[i].d);
      end
      chk(rows[i].a, rows[i].m, rows[i].e);
    end
    wr(SIC_OFS_PORT_CTRL, 16'h3000);
    wr(SIC_OFS_DATA, 16'h00a5);
    link(8, 8'h3c);
    cmp({8'h00, rxb}, 16'h00a5);
    chk(SIC_OFS_STATUS, 16'h00ff, 16'h0006);
    chk(SIC_OFS_PORT_CTRL, 16'h0080, 16'h0080);
    irq_is(1'b1);
    wr(SIC_OFS_IRQ_CLR, 16'h0002);
    chk(SIC_OFS_STATUS, 16'h00ff, 16'h0004);
    wr(SIC_OFS_IRQ_EN, 16'h0003);
    irq_is(1'b0);
    wr(SIC_OFS_IRQ_EN, 16'h0004);
    irq_is(1'b1);
    chk(SIC_OFS_DATA, 16'h00ff, 16'h003c);
    chk(SIC_OFS_CRC_CTRL, 16'h0200, 16'h0000);
    // Three bits each way
    wr(SIC_OFS_PORT_CTRL, 16'h301b);
    wr(SIC_OFS_DATA, 16'h00f6);
    link(3, 8'h05);
    cmp({8'h00, rxb}, 16'h0006);
    chk(SIC_OFS_DATA, 16'h00ff, 16'h0005);
    // Clocked with nothing loaded
    link(1, 8'h01);
    chk(SIC_OFS_STATUS, 16'h0080, 16'h0080);
    chk(SIC_OFS_PORT_CTRL, 16'h0080, 16'h0080);
    wr(SIC_OFS_PORT_CTRL, 16'h701b);
    chk(SIC_OFS_STATUS, 16'h0080, 16'h0000);
    // Fill the receive FIFO, then one more
    wr(SIC_OFS_CRC_CTRL, 16'h3800);
    wr(SIC_OFS_PORT_CTRL, 16'h3400);
    for (int i = 0; i < SIC_RXF_DEPTH; i++)
    begin
      link(8, 8'h11 + i[7:0]);
    end
    chk(SIC_OFS_PORT_CTRL, 16'h0040, 16'h0040);
    chk(SIC_OFS_STATUS, 16'h0080, 16'h0000);
    link(8, 8'h5a);
    chk(SIC_OFS_STATUS, 16'h0080, 16'h0080);
    chk(SIC_OFS_CRC_CTRL, 16'h0200, 16'h0200);
    wr(SIC_OFS_CRC_CTRL, 16'h1000);
    chk(SIC_OFS_CRC_CTRL, 16'h0600, 16'h0400);
    wr(SIC_OFS_PORT_CTRL, 16'h7400);
    chk(SIC_OFS_PORT_CTRL, 16'h0040, 16'h0000);
    // Block mode completion
    wr(SIC_OFS_PORT_CTRL, 16'h0000);
    wr(SIC_OFS_IRQ_EN, 16'h0001);
    block_done <= 1'b1;
    @(posedge sys_clk);
    block_done <= 1'b0;
    chk(SIC_OFS_STATUS, 16'h0001, 16'h0001);
    irq_is(1'b1);
    wr(SIC_OFS_IRQ_CLR, 16'h0001);
    chk(SIC_OFS_STATUS, 16'h0001, 16'h0000);
    irq_is(1'b0);
    // Reset again in mid-run
    reset <= 1'b1;
    @(posedge sys_clk);
    reset <= 1'b0;
    @(posedge sys_clk);
    chk(SIC_OFS_IRQ_EN, 16'hffff, 16'h0000);
    chk(SIC_OFS_CRC_CTRL, 16'hf800, 16'h0000);
    stop_test;
  end
endmodule
`default_nettype wire
